/* verilog/wps_pkg.sv */
// shared constants, register map and carrier types of the watchdog,
// power-save and external edge interrupt block
// assumes a 100 MHz pclk and a word-wide APB register window
package wps_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          CLK_MHZ      = 100;
   localparam int          MCYC_DIV     = 4;
   localparam logic [1:0]  MCYC_LAST    = 2'(MCYC_DIV - 1);
   localparam logic [3:0]  IRQ_LAT_MCYC = 4'hC;
   localparam logic [7:0]  BIT_TOP      = 8'hFF;
   localparam logic [7:0]  RC_HALF      = 8'h80;
   // ------------------------------------------------------------
   // register map: printed index, byte address is four times it
   // ------------------------------------------------------------
   localparam logic [7:0]  EDGE_IDX     = 8'hE6;
   localparam logic [7:0]  CMP_IDX      = 8'hE7;
   localparam logic [7:0]  CKCTL_IDX    = 8'hE8;
   localparam logic [7:0]  FLAGS_IDX    = 8'hE9;
   localparam logic [7:0]  STATUS_IDX   = 8'hEA;
   localparam int          ADDR_W       = 12;
   localparam logic [11:0] EDGE_ADDR    = {2'h0, EDGE_IDX, 2'h0};
   localparam logic [11:0] CMP_ADDR     = {2'h0, CMP_IDX, 2'h0};
   localparam logic [11:0] CKCTL_ADDR   = {2'h0, CKCTL_IDX, 2'h0};
   localparam logic [11:0] FLAGS_ADDR   = {2'h0, FLAGS_IDX, 2'h0};
   localparam logic [11:0] STATUS_ADDR  = {2'h0, STATUS_IDX, 2'h0};
   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int          CMP_CLR_BIT  = 7;
   localparam int          CK_WAKE_BIT  = 6;
   localparam int          CK_RC_BIT    = 5;
   localparam int          CK_WRS_BIT   = 4;
   localparam int          FLAG_WDT     = 2;
   localparam logic [1:0]  EDGE_FALL    = 2'h1;
   localparam logic [1:0]  EDGE_RISE    = 2'h2;
   localparam logic [1:0]  EDGE_BOTH    = 2'h3;
   localparam logic [7:0]  EDGE_RST     = 8'h00;
   localparam logic [7:0]  CMP_RST      = 8'h7F;
   localparam logic [7:0]  CKCTL_RST    = 8'h00;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      M_RUN, M_STOP, M_WAKE, M_RCW, M_STAB
   } wps_mode_t;

   typedef struct packed {
      logic halt_exec;
      logic i_flag;
      logic ack_a;
      logic ack_b;
      logic other_pending;
   } wps_cpu_in_t;

   typedef struct packed {
      logic cpu_stop;
      logic pc_hold;
      logic osc_run;
      logic timer_zero_run;
      logic presc2048_run;
      logic rc_osc_run;
   } wps_pm_out_t;

   typedef struct packed {
      logic        resume;
      logic        resume_vec;
      logic        wdt_rst;
      logic [1:0]  req;
   } wps_cpu_out_t;

   typedef struct packed {
      wps_mode_t       mode;
      logic [1:0]      mcyc_cnt;
      logic [1:0]      pin_q;
      logic [2:0]      flags;
      logic [1:0][3:0] age;
      logic [7:0]      edge_r;
      logic [7:0]      cmp_r;
      logic [7:0]      ckctl_r;
      logic [6:0]      wcnt;
      logic [7:0]      rcpre;
      logic [7:0]      bitcnt;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
      wps_pm_out_t     pm;
      wps_cpu_out_t    co;
   } wps_state_t;
endpackage

/* verilog/wps_top.sv */
// watchdog, halt power-save controller and external edge interrupts
// assumes all inputs synchronous to pclk; bit_tick, rc_tick and
// timer_zero_ovf are one-cycle pulses from the surrounding timers
`timescale 1ns/1ps
module wps_top
   import wps_pkg::*;
(
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [wps_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [1:0]                  ext_irq,
   input  wire logic                        bit_tick,
   input  wire logic                        rc_tick,
   input  wire logic                        timer_zero_ovf,
   input  wire wps_pkg::wps_cpu_in_t        cpu_in,
   output wps_pkg::wps_cpu_out_t            cpu_out,
   output wps_pkg::wps_pm_out_t             pm_out
);
   import wps_pkg::*;

   wps_state_t q;
   wps_state_t s;
   logic       mcyc;
   logic       bit_ovf;
   logic       any_det;
   logic       match;
   logic [1:0] det;

   assign mcyc    = (q.mcyc_cnt == MCYC_LAST);
   assign bit_ovf = bit_tick && (q.bitcnt == BIT_TOP)
                    && (q.mode == M_RUN || q.mode == M_STAB);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic       wr;
      logic [6:0] nc;
      logic [7:0] pre_n;
      logic [1:0] sel;
      s             = q;
      wr            = psel && penable && pwrite && q.pready;
      nc            = q.wcnt + 7'h01;
      pre_n         = q.rcpre + 8'h01;
      sel           = 2'h0;
      det           = 2'h0;
      match         = 1'b0;
      s.co.resume     = 1'b0;
      s.co.resume_vec = 1'b0;
      s.co.wdt_rst    = 1'b0;
      s.mcyc_cnt    = mcyc ? 2'h0 : q.mcyc_cnt + 2'h1;

      // apb: zero-wait answer, data set in the setup cycle
      if (psel && !penable) begin
         s.pready  = 1'b1;
         s.pslverr = 1'b0;
         s.prdata  = 32'h0000_0000;
         case (paddr)
            EDGE_ADDR:   s.prdata = {24'h000000, q.edge_r};
            CMP_ADDR:    s.prdata = {24'h000000, q.cmp_r};
            CKCTL_ADDR:  s.prdata = {24'h000000, q.ckctl_r};
            FLAGS_ADDR:  s.prdata = {29'h0, q.flags};
            STATUS_ADDR: s.prdata = {13'h0, q.mode, q.bitcnt,
                                     1'b0, q.wcnt};
            default:     s.pslverr = 1'b1;
         endcase
      end else if (q.pready) begin
         s.pready  = 1'b0;
         s.pslverr = 1'b0;
      end

      if (wr) begin
         case (paddr)
            EDGE_ADDR:  s.edge_r  = pwdata[7:0];
            CKCTL_ADDR: s.ckctl_r = pwdata[7:0];
            FLAGS_ADDR: s.flags   = pwdata[2:0];
            default:    s.edge_r  = s.edge_r;
         endcase
      end

      // vectoring clears the edge flag before any new set lands
      if (cpu_in.ack_a)
         s.flags[0] = 1'b0;
      if (cpu_in.ack_b)
         s.flags[1] = 1'b0;

      // edge sampling, once per machine cycle
      for (int i = 0; i < 2; i++) begin
         sel = q.edge_r[2*i +: 2];
         if (mcyc) begin
            s.pin_q[i] = ext_irq[i];
            if ((ext_irq[i] && !q.pin_q[i] && sel[1]) ||
                (!ext_irq[i] && q.pin_q[i] && sel[0]))
               det[i] = 1'b1;
         end
         if (det[i])
            s.flags[i] = 1'b1;
      end
      any_det = |det;

      // request age in machine cycles since the flag rose
      for (int i = 0; i < 2; i++) begin
         if (!q.flags[i])
            s.age[i] = 4'h0;
         else if (mcyc && q.age[i] != IRQ_LAT_MCYC)
            s.age[i] = q.age[i] + 4'h1;
         s.co.req[i] = q.flags[i] && (q.age[i] == IRQ_LAT_MCYC);
      end

      // basic interval timer, also the wake-up stabilisation count
      if (bit_tick && (q.mode == M_RUN || q.mode == M_STAB))
         s.bitcnt = q.bitcnt + 8'h01;

      // watchdog counter and its two clock sources
      if (q.mode == M_RUN && bit_ovf) begin
         if (nc == q.cmp_r[6:0]) begin
            match  = 1'b1;
            s.wcnt = 7'h00;
         end else
            s.wcnt = nc;
      end else if (q.mode == M_RCW && rc_tick) begin
         s.rcpre = pre_n;
         if (q.wcnt == q.cmp_r[6:0] && pre_n == RC_HALF) begin
            match   = 1'b1;
            s.wcnt  = 7'h00;
            s.rcpre = 8'h00;
         end else if (pre_n == 8'h00)
            s.wcnt = nc;
      end

      // counter clear bit: holds the counter, drops on machine cycle
      if (q.cmp_r[CMP_CLR_BIT]) begin
         s.wcnt = 7'h00;
         if (mcyc)
            s.cmp_r[CMP_CLR_BIT] = 1'b0;
      end
      if (wr && paddr == CMP_ADDR) begin
         s.cmp_r = pwdata[7:0];
         if (pwdata[CMP_CLR_BIT])
            s.wcnt = 7'h00;
      end

      if (match) begin
         if (q.ckctl_r[CK_WRS_BIT])
            s.co.wdt_rst = 1'b1;
         else
            s.flags[FLAG_WDT] = 1'b1;
      end

      // power-save sequencing
      case (q.mode)
         M_RUN: begin
            if (cpu_in.halt_exec) begin
               if ((|q.flags) || cpu_in.other_pending)
                  s.co.resume = 1'b1;
               else if (q.ckctl_r[CK_WAKE_BIT])
                  s.mode = M_WAKE;
               else if (q.ckctl_r[CK_RC_BIT]) begin
                  s.mode  = M_RCW;
                  s.rcpre = 8'h00;
                  s.wcnt  = 7'h00;
               end else
                  s.mode = M_STOP;
            end
         end
         M_STOP: begin
            if (any_det) begin
               s.mode   = M_STAB;
               s.bitcnt = 8'h00;
            end
         end
         M_WAKE: begin
            if (any_det || timer_zero_ovf) begin
               s.mode          = M_RUN;
               s.co.resume     = 1'b1;
               s.co.resume_vec = cpu_in.i_flag;
            end
         end
         M_RCW: begin
            if (match && q.ckctl_r[CK_WRS_BIT])
               s.mode = M_RUN;
            else if (any_det || match) begin
               s.mode   = M_STAB;
               s.bitcnt = 8'h00;
            end
         end
         M_STAB: begin
            if (bit_ovf) begin
               s.mode          = M_RUN;
               s.co.resume     = 1'b1;
               s.co.resume_vec = cpu_in.i_flag;
            end
         end
         default: s.mode = M_RUN;
      endcase

      // mode-dependent enables, registered with the mode
      s.pm.cpu_stop      = (s.mode != M_RUN);
      s.pm.pc_hold       = (s.mode != M_RUN);
      s.pm.osc_run       = (s.mode == M_RUN || s.mode == M_WAKE
                            || s.mode == M_STAB);
      s.pm.timer_zero_run    = (s.mode == M_RUN || s.mode == M_WAKE);
      s.pm.presc2048_run = (s.mode == M_WAKE);
      s.pm.rc_osc_run    = (s.mode == M_RCW);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q         <= '0;
         q.mode    <= M_RUN;
         q.edge_r  <= EDGE_RST;
         q.cmp_r   <= CMP_RST;
         q.ckctl_r <= CKCTL_RST;
      end else begin
         q <= s;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;
   assign cpu_out = q.co;
   assign pm_out  = q.pm;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   edge_rise_a: assert property (
      (mcyc && ext_irq[0] && !q.pin_q[0] && q.edge_r[1]
       && !cpu_in.ack_a) |=> q.flags[0])
      else $error("rising edge on pin a not flagged");

   sample_mcyc_a: assert property (
      (q.pin_q != $past(q.pin_q)) |-> $past(mcyc))
      else $error("pin sampled outside a machine cycle");

   req_latency_a: assert property (
      $rose(q.flags[0]) |-> !q.co.req[0] [*8])
      else $error("request shown before latency elapsed");

   wdt_match_a: assert property (
      (q.mode == M_RUN && bit_ovf && !q.ckctl_r[CK_WRS_BIT]
       && !q.cmp_r[CMP_CLR_BIT] && !(psel && pwrite)
       && q.wcnt + 7'h01 == q.cmp_r[6:0])
      |=> q.flags[FLAG_WDT] && q.wcnt == 7'h00)
      else $error("watchdog match did not raise flag");

   wdt_route_a: assert property (
      (q.mode == M_RUN && bit_ovf && q.ckctl_r[CK_WRS_BIT]
       && !q.cmp_r[CMP_CLR_BIT]
       && q.wcnt + 7'h01 == q.cmp_r[6:0])
      |=> q.co.wdt_rst ##1 !q.co.wdt_rst)
      else $error("watchdog reset pulse missing");

   clr_self_a: assert property (
      $rose(q.cmp_r[CMP_CLR_BIT]) |-> (q.wcnt == 7'h00)
      ##[1:4] !q.cmp_r[CMP_CLR_BIT])
      else $error("counter clear bit did not self clear");

   halt_pend_a: assert property (
      (q.mode == M_RUN && cpu_in.halt_exec && (|q.flags))
      |=> q.co.resume && q.mode == M_RUN && !q.pm.cpu_stop)
      else $error("halt with pending flag entered power save");

   stop_enter_a: assert property (
      (q.mode == M_RUN && cpu_in.halt_exec && !(|q.flags)
       && !cpu_in.other_pending && q.ckctl_r[6:5] == 2'h0)
      |=> q.mode == M_STOP && q.pm.cpu_stop && !q.pm.osc_run)
      else $error("halt did not enter full stop");

   stab_exit_a: assert property (
      (q.mode == M_STAB && bit_ovf)
      |=> q.co.resume && q.mode == M_RUN
          && q.co.resume_vec == $past(cpu_in.i_flag))
      else $error("stabilisation exit wrong");

   stop_hold_a: assert property (
      (q.mode == M_STOP && !any_det) |=> q.mode == M_STOP)
      else $error("full stop left without pin edge");

   wake_gate_a: assert property (
      q.mode == M_WAKE |-> q.pm.timer_zero_run && q.pm.presc2048_run
                           && !q.pm.rc_osc_run && q.pm.pc_hold)
      else $error("wake timer enables wrong");

   ack_clear_a: assert property (
      (cpu_in.ack_b && !det[1]) |=> !q.flags[1])
      else $error("vectoring did not clear flag");

   stop_wake_c: cover property (
      q.mode == M_STOP ##1 q.mode == M_STAB);
   rc_reset_c: cover property (q.mode == M_RCW ##1 q.co.wdt_rst);
   halt_pend_c: cover property (
      cpu_in.halt_exec && q.mode == M_RUN ##1 q.co.resume);
   wake_exit_c: cover property (
      q.mode == M_WAKE ##1 q.co.resume);
endmodule

/* tb/wps_cpu_model.sv */
// cpu core stand-in: halt pulses, interrupt enable, vectoring acks
// assumes the bench moves halt_req, ie, oth and ack_en after pclk edges
`timescale 1ns/1ps
module wps_cpu_model
   import wps_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  halt_req,
   input  wire logic                  ie,
   input  wire logic                  oth,
   input  wire logic                  ack_en,
   input  wire wps_pkg::wps_cpu_out_t cpu_out,
   output wps_pkg::wps_cpu_in_t       cpu_in
);
   import wps_pkg::*;
   logic       halt_q;
   logic [1:0] ack;
   logic [1:0] done;

   // -----------------------------------------------------------------
   // one ack per channel while enabled, only with interrupts enabled
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_q <= 1'b0;
         ack    <= 2'h0;
         done   <= 2'h0;
      end else begin
         halt_q <= halt_req;
         for (int i = 0; i < 2; i++) begin
            ack[i]  <= ack_en & ie & cpu_out.req[i]
                       & ~ack[i] & ~done[i];
            done[i] <= ack_en & (done[i] | ack[i]);
         end
      end
   end

   // halt is a single pulse per request, on the rising edge of halt_req
   assign cpu_in = {halt_req & ~halt_q, ie, ack[0], ack[1], oth};
endmodule

/* tb/testbench.sv */
// self-checking bench of the watchdog, power-save and edge interrupts
// assumes wps_top on APB and the cpu stand-in on its cpu side
`timescale 1ns/1ps
module testbench;
   import wps_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, err, res_vec;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              pready, pslverr, bit_tick, rc_tick, timer_zero_ovf;
   logic              halt_req, ie, oth, ack_en;
   logic [1:0]        ext_irq;
   wps_cpu_in_t       cpu_in;
   wps_cpu_out_t      cpu_out;
   wps_pm_out_t       pm_out;
   int                n_mismatch, cmp_count, n_res, n_rst, lat;
   logic [31:0]       seed;

   wps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_irq(ext_irq), .bit_tick(bit_tick), .rc_tick(rc_tick),
      .timer_zero_ovf(timer_zero_ovf), .cpu_in(cpu_in), .cpu_out(cpu_out),
      .pm_out(pm_out));
   wps_cpu_model cpu (.pclk(pclk), .presetn(presetn), .halt_req(halt_req),
      .ie(ie), .oth(oth), .ack_en(ack_en), .cpu_out(cpu_out),
      .cpu_in(cpu_in));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic int rnd;
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return int'(seed[1:0]);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      cyc(1);
      penable <= 1'b1;
      cyc(1);
      while (pready !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      rd  = prdata;
      err = pslverr;
      if (n == 20) chk(32'h0, 32'h1);
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle cycle, so the next setup never re-drives psel in this step
      cyc(1);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic md(input logic [2:0] e);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(32'(rd[18:16]), 32'(e));
   endtask
   task automatic bt(input int n);
      repeat (n) begin
         bit_tick <= 1'b1;
         cyc(1);
         bit_tick <= 1'b0;
         cyc(1 + rnd());
      end
   endtask
   task automatic rct(input int n);
      repeat (n) begin
         rc_tick <= 1'b1;
         cyc(1);
         rc_tick <= 1'b0;
         cyc(1);
      end
   endtask
   task automatic pulse_t0;
      timer_zero_ovf <= 1'b1;
      cyc(1);
      timer_zero_ovf <= 1'b0;
      cyc(3);
   endtask
   task automatic halt;
      halt_req <= 1'b1;
      cyc(1);
      halt_req <= 1'b0;
      cyc(3);
   endtask

   always @(posedge pclk) begin
      if (cpu_out.resume === 1'b1) begin
         n_res++;
         res_vec = cpu_out.resume_vec;
      end
      if (cpu_out.wdt_rst === 1'b1) n_rst++;
   end

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #500000;
      n_mismatch++;
      print_verdict();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, bit_tick, rc_tick, timer_zero_ovf} = 6'h00;
      {halt_req, ie, oth, ack_en} = 4'h0;
      paddr = '0;
      pwdata = 32'h0;
      ext_irq = 2'h0;
      seed = 32'h4;
      presetn = 1'b0;
      cyc(5);
      presetn <= 1'b1;
      cyc(1);
      rc(EDGE_ADDR, 32'(EDGE_RST));
      rc(CMP_ADDR, 32'(CMP_RST));
      rc(CKCTL_ADDR, 32'(CKCTL_RST));
      rc(FLAGS_ADDR, 32'h0);
      rc(STATUS_ADDR, 32'h0);
      chk(32'(pm_out), 32'h0C);
      rc(12'h000, 32'h0);
      chk(32'(err), 32'h1);
      wr(CMP_ADDR, 32'h83);
      cyc(8);
      rc(CMP_ADDR, 32'h03);
      bt(767);
      rc(FLAGS_ADDR, 32'h0);
      rc(STATUS_ADDR, 32'h0000FF02);
      bt(1);
      cyc(3);
      rc(FLAGS_ADDR, 32'h4);
      bt(300);
      wr(CMP_ADDR, 32'h83);
      cyc(8);
      rc(STATUS_ADDR, 32'h00002C00);
      wr(FLAGS_ADDR, 32'h0);
      wr(CKCTL_ADDR, 32'h10);
      n_rst = 0;
      bt(724);
      cyc(3);
      chk(32'(n_rst), 32'h1);
      rc(FLAGS_ADDR, 32'h0);
      wr(CKCTL_ADDR, 32'h0);
      wr(CMP_ADDR, 32'h80);
      for (int m = 0; m < 4; m++) begin
         wr(EDGE_ADDR, 32'(m * 5));
         wr(FLAGS_ADDR, 32'h0);
         ext_irq <= 2'h3;
         cyc(10);
         rc(FLAGS_ADDR, m[1] ? 32'h3 : 32'h0);
         wr(FLAGS_ADDR, 32'h0);
         ext_irq <= 2'h0;
         cyc(10);
         rc(FLAGS_ADDR, m[0] ? 32'h3 : 32'h0);
      end
      wr(FLAGS_ADDR, 32'h0);
      ie <= 1'b1;
      ack_en <= 1'b1;
      ext_irq <= 2'h3;
      lat = 0;
      while (cpu_out.req[0] !== 1'b1 && lat < 100) begin
         cyc(1);
         lat++;
      end
      chk(32'(lat >= 48 && lat <= 56), 32'h1);
      cyc(6);
      rc(FLAGS_ADDR, 32'h0);
      chk(32'(cpu_out.req), 32'h0);
      ack_en <= 1'b0;
      ext_irq <= 2'h0;
      cyc(10);
      wr(FLAGS_ADDR, 32'h0);
      n_res = 0;
      halt();
      chk(32'(pm_out), 32'h30);
      pulse_t0();
      md(3'h1);
      ext_irq <= 2'h1;
      cyc(8);
      md(3'h4);
      bt(255);
      cyc(3);
      chk(32'(n_res), 32'h0);
      bt(1);
      cyc(3);
      chk(32'(n_res), 32'h1);
      chk(32'(res_vec), 32'h1);
      rc(EDGE_ADDR, 32'hF);
      ext_irq <= 2'h0;
      cyc(8);
      wr(FLAGS_ADDR, 32'h0);
      wr(CKCTL_ADDR, 32'h40);
      ie <= 1'b0;
      halt();
      chk(32'(pm_out), 32'h3E);
      pulse_t0();
      chk(32'(n_res), 32'h2);
      chk(32'(res_vec), 32'h0);
      wr(CMP_ADDR, 32'h81);
      wr(CKCTL_ADDR, 32'h20);
      halt();
      chk(32'(pm_out), 32'h31);
      rct(383);
      md(3'h3);
      rct(1);
      cyc(3);
      md(3'h4);
      bt(256);
      cyc(3);
      chk(32'(n_res), 32'h3);
      wr(FLAGS_ADDR, 32'h0);
      wr(CMP_ADDR, 32'h81);
      wr(CKCTL_ADDR, 32'h30);
      n_rst = 0;
      halt();
      rct(384);
      cyc(3);
      chk(32'(n_rst), 32'h1);
      md(3'h0);
      wr(CKCTL_ADDR, 32'h0);
      wr(CMP_ADDR, 32'h80);
      wr(FLAGS_ADDR, 32'h4);
      halt();
      chk(32'(n_res), 32'h4);
      md(3'h0);
      wr(FLAGS_ADDR, 32'h0);
      oth <= 1'b1;
      halt();
      chk(32'(n_res), 32'h5);
      oth <= 1'b0;
      halt();
      md(3'h1);
      presetn <= 1'b0;
      cyc(2);
      presetn <= 1'b1;
      cyc(1);
      md(3'h0);
      rc(EDGE_ADDR, 32'(EDGE_RST));
      chk(32'(pm_out), 32'h0C);
      print_verdict();
   end
endmodule
